/* qpw_wiper_ctrl.sv */
/*
 Serial load path, presets, shutdown and tap decode for four wipers.
 Assumes serial pins come from outside and are resynchronised here;
 link clock must be slow (<= 1/4 of sys_clk) for edge detection.
*/
`timescale 1ns/1ps
module qpw_wiper_ctrl
    import qpw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Pins
    input wire logic interface_select_pin_i,
    input wire logic power_down_pin_n_i,
    input wire logic midscale_preset_pin_n_i,
    input wire qpw_link_t link_i,
    // Serial output, open drain: oe low while driving low
    output logic serial_out_open_drain_o,
    output logic serial_out_open_drain_oe_n_o,
    // Resistor switches and interface enables
    output logic [CHANNELS-1:0] term_a_connect_o,
    output logic [CHANNELS*TAPS-1:0] tap_select_o,
    output logic spi_enabled_o,
    output logic i2c_enabled_o
);
    qpw_link_t link_s1_reg;
    qpw_link_t link_s2_reg;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic sclk_d_reg;
    logic csn_d_reg;
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] shift_next;
    logic serial_out_reg;
    logic [31:0] codes;
    logic commit;
    logic sclk_rise;
    logic sclk_fall;
    logic power_down;
    logic preset;
    logic spi_sel;
    qpw_word_t wr_word;

    function automatic logic [TAPS-1:0] tap_decode(input logic [7:0] code);
        logic [TAPS-1:0] onehot;
        onehot = '0;
        onehot[code] = 1'b1;
        return onehot;
    endfunction : tap_decode

    // Two-stage synchronisers; only stage two is read
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            link_s1_reg <= '{sclk: 1'b0, csn: 1'b1, serial_in: 1'b0};
            link_s2_reg <= '{sclk: 1'b0, csn: 1'b1, serial_in: 1'b0};
            pin_s1_reg <= 3'b110;
            pin_s2_reg <= 3'b110;
        end else begin
            link_s1_reg <= link_i;
            link_s2_reg <= link_s1_reg;
            pin_s1_reg <= {power_down_pin_n_i, midscale_preset_pin_n_i,
                           interface_select_pin_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    always_comb begin
        power_down = !pin_s2_reg[2];
        preset = !pin_s2_reg[1];
        spi_sel = !pin_s2_reg[0];
        sclk_rise = link_s2_reg.sclk && !sclk_d_reg;
        sclk_fall = !link_s2_reg.sclk && sclk_d_reg;
        commit = spi_sel && link_s2_reg.csn && !csn_d_reg;
        shift_next = {shift_reg[WORD_BITS-2:0], link_s2_reg.serial_in};
        wr_word = shift_reg;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sclk_d_reg <= 1'b0;
            csn_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= link_s2_reg.sclk;
            csn_d_reg <= link_s2_reg.csn;
        end
    end

    // Shifter keeps only the newest ten bits; frozen while deselected
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            shift_reg <= '0;
        end else if (spi_sel && !link_s2_reg.csn && sclk_rise) begin
            shift_reg <= shift_next;
        end
    end

    qpw_latch_bank u_bank (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .preset_i(preset),
        .wr_en_i(commit && !preset),
        .wr_word_i(wr_word),
        .rd_chan_i(2'b00),
        .rd_code_o(),
        .all_codes_o(codes)
    );

    // Output shifts on falling edge, so the next stage samples on rise
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            serial_out_reg <= 1'b1;
        end else if (power_down) begin
            serial_out_reg <= 1'b1;
        end else if (!link_s2_reg.csn && sclk_fall) begin
            serial_out_reg <= shift_reg[WORD_BITS-1];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            serial_out_open_drain_o <= 1'b0;
            serial_out_open_drain_oe_n_o <= 1'b1;
            spi_enabled_o <= 1'b0;
            i2c_enabled_o <= 1'b0;
        end else begin
            serial_out_open_drain_o <= 1'b0;
            serial_out_open_drain_oe_n_o <= serial_out_reg;
            spi_enabled_o <= spi_sel;
            i2c_enabled_o <= !spi_sel;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            term_a_connect_o <= '1;
            for (int c = 0; c < CHANNELS; c++) begin
                tap_select_o[c*TAPS +: TAPS] <= tap_decode(MIDSCALE);
            end
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                term_a_connect_o[c] <= !power_down;
                if (power_down) begin
                    tap_select_o[c*TAPS +: TAPS] <= tap_decode(8'h00);
                end else begin
                    tap_select_o[c*TAPS +: TAPS] <=
                        tap_decode(codes[c*8 +: 8]);
                end
            end
        end
    end

    // Output register lags the forced level by one edge, hence the ##1
    a_down_out_high: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        power_down |=> ##1 serial_out_open_drain_oe_n_o)
        else $error("serial out not released in shutdown");

    a_down_term_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        power_down |=> term_a_connect_o == '0 && tap_select_o[0])
        else $error("shutdown did not tie wiper to B");

    a_preset_mid: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        preset |=> codes == {CHANNELS{MIDSCALE}})
        else $error("preset did not load midscale");

    a_commit_load: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        commit && !preset && shift_reg[9:8] == 2'b11
        |=> codes[31:24] == $past(shift_reg[7:0]))
        else $error("commit did not load channel four");

    a_csn_hold: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        link_s2_reg.csn && csn_d_reg |=> $stable(shift_reg))
        else $error("shifter moved while deselected");

    a_shift_rise: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        spi_sel && !link_s2_reg.csn && sclk_rise
        |=> shift_reg[0] == $past(link_s2_reg.serial_in))
        else $error("bit not shifted on rising clock");

    a_no_commit_hold: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        !commit && !preset |=> $stable(codes))
        else $error("latch changed without commit");

    a_decode_live: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        !power_down |=>
            tap_select_o[TAPS-1:0] == tap_decode($past(codes[7:0])))
        else $error("tap decode mismatch");

    a_mode_sel: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        spi_sel |=> spi_enabled_o && !i2c_enabled_o)
        else $error("interface select mismatch");
endmodule : qpw_wiper_ctrl

/* qpw_pkg.sv */
/*
 Shared constants and carrier types for the quad wiper control block.
 Assumes a 25 MHz system clock and pins sampled through synchronisers.
*/
// Function
// - Power-up presets all wiper latches to midscale
// - Shutdown opens terminal A, wiper to B
// - Shutdown retains latches, still accepts writes
// - Shutdown release drives wipers from latches
// - Decode each 8-bit latch to one-of-256
// - Code zero selects terminal B connection
// - Select pin low enables three-wire interface
// - Shift input on rising clock while selected
// - Address 00..11 loads latches one to four
// - Commit shift register on chip select rise
// - Only last ten bits are committed
// - Shutdown releases open-drain output high
// - Preset pin loads midscale, kept after release
// - Serial output changes on falling clock edge
package qpw_pkg;
    localparam int WORD_BITS = 10;
    localparam int DATA_BITS = 8;
    localparam int CHANNELS = 4;
    localparam int TAPS = 256;
    localparam logic [7:0] MIDSCALE = 8'h80;
    localparam int ADDR_HI = 9;
    localparam int ADDR_LO = 8;

    typedef struct packed {
        logic [1:0] chan;
        logic [7:0] code;
    } qpw_word_t;

    typedef struct packed {
        logic sclk;
        logic csn;
        logic serial_in;
    } qpw_link_t;
endpackage : qpw_pkg

/* qpw_latch_bank.sv */
/*
 Four 8-bit wiper latches with a registered read port.
 Assumes write and preset requests arrive on the system clock.
*/
`timescale 1ns/1ps
module qpw_latch_bank
    import qpw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Control
    input wire logic preset_i,
    input wire logic wr_en_i,
    input wire qpw_word_t wr_word_i,
    // Read
    input wire logic [1:0] rd_chan_i,
    output logic [7:0] rd_code_o,
    output logic [31:0] all_codes_o
);
    logic [7:0] mem_reg [CHANNELS];

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || preset_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                mem_reg[i] <= MIDSCALE;
            end
        end else if (wr_en_i) begin
            mem_reg[wr_word_i.chan] <= wr_word_i.code;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rd_code_o <= MIDSCALE;
        end else begin
            rd_code_o <= mem_reg[rd_chan_i];
        end
    end

    always_comb begin
        all_codes_o = {mem_reg[3], mem_reg[2], mem_reg[1], mem_reg[0]};
    end
endmodule : qpw_latch_bank

/* qpw_spi_master.sv */
/*
 Serial master model driving the three-wire load path.
 Assumes the 25 MHz system clock; link clock period is 8 system clocks.
*/
`timescale 1ns/1ps
module qpw_spi_master
    import qpw_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Link
    output qpw_link_t link_o
);
    initial link_o = '{sclk: 1'b0, csn: 1'b1, serial_in: 1'b0};

    task automatic half();
        repeat (4) @(posedge sys_clk_i);
        #2;
    endtask : half

    // Shifts the low n bits MSB first; hold_cs keeps chip select high
    task automatic send(input logic [19:0] bits, input int n,
                        input logic hold_cs);
        link_o.csn = hold_cs;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            link_o.serial_in = bits[i];
            half();
            link_o.sclk = 1'b1;
            half();
            link_o.sclk = 1'b0;
        end
        half();
        link_o.csn = 1'b1;
        // Released data line must not look like the last bit
        link_o.serial_in = ~link_o.serial_in;
        half();
        half();
    endtask : send
endmodule : qpw_spi_master

/* test_qpw_wiper_ctrl.sv */
/*
 Self-checking bench for the quad wiper control block.
 Assumes the serial master model drives the link pins.
*/
`timescale 1ns/1ps
module test_qpw_wiper_ctrl
    import qpw_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic sel = 1'b0;
    logic pd_n = 1'b1;
    logic pre_n = 1'b1;
    qpw_link_t link;
    logic out_val, oe_n, spi_en, i2c_en;
    logic [3:0] term_a;
    logic [1023:0] taps;
    logic [7:0] code [4];
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    qpw_spi_master qpw_spi_master_i (.sys_clk_i(sys_clk_i), .link_o(link));

    qpw_wiper_ctrl qpw_wiper_ctrl_i (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .interface_select_pin_i(sel), .power_down_pin_n_i(pd_n),
        .midscale_preset_pin_n_i(pre_n), .link_i(link),
        .serial_out_open_drain_o(out_val),
        .serial_out_open_drain_oe_n_o(oe_n),
        .term_a_connect_o(term_a), .tap_select_o(taps),
        .spi_enabled_o(spi_en), .i2c_enabled_o(i2c_en));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [1023:0] seen,
                         input logic [1023:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask : tick

    // Expected taps and terminal A switches; sd means shutdown
    task automatic check_all(input logic sd, input string what);
        logic [1023:0] exp;
        exp = '0;
        for (int c = 0; c < 4; c++) begin
            exp[c * TAPS + (sd ? 0 : int'(code[c]))] = 1'b1;
        end
        tick(3);
        check(what, taps, exp);
        check("term_a", term_a, sd ? 4'h0 : 4'hF);
        $display("test %s done", what);
    endtask : check_all

    task automatic write(input logic [1:0] ch, input logic [7:0] val,
                         input logic take);
        qpw_spi_master_i.send({10'h000, ch, val}, 10, 1'b0);
        if (take) code[ch] = val;
    endtask : write

    initial begin
        for (int c = 0; c < 4; c++) code[c] = MIDSCALE;
        tick(16);
        srst_i = 1'b0;
        tick(4);
        check_all(1'b0, "reset");
        check("modes", {i2c_en, spi_en}, 2'b01);
        write(2'b00, 8'h00, 1'b1);
        write(2'b01, 8'h01, 1'b1);
        // Ten bits in: the word's first bit (channel high bit 0) waits
        // on the serial output for the next stage, so the line is pulled
        check("out_oe_n", oe_n, 1'b0);
        check("out_val", out_val, 1'b0);
        write(2'b10, 8'hFF, 1'b1);
        write(2'b11, 8'h5A, 1'b1);
        check_all(1'b0, "decode");
        qpw_spi_master_i.send({2'b01, 8'hA5, 2'b10, 8'h3C}, 20,
                              1'b0);
        code[2] = 8'h3C;
        check_all(1'b0, "overlong");
        qpw_spi_master_i.send({10'h000, 2'b00, 8'h11}, 10, 1'b1);
        check_all(1'b0, "deselected");
        pd_n = 1'b0;
        tick(6);
        check_all(1'b1, "shutdown");
        check("oe_n", oe_n, 1'b1);
        write(2'b01, 8'h77, 1'b1);
        pd_n = 1'b1;
        check_all(1'b0, "wake");
        pre_n = 1'b0;
        for (int c = 0; c < 4; c++) code[c] = MIDSCALE;
        write(2'b11, 8'h22, 1'b0);
        check_all(1'b0, "preset");
        pre_n = 1'b1;
        check_all(1'b0, "preset off");
        sel = 1'b1;
        tick(4);
        check("modes", {i2c_en, spi_en}, 2'b10);
        write(2'b00, 8'h44, 1'b0);
        check_all(1'b0, "two-wire");
        print_verdict();
    end
endmodule : test_qpw_wiper_ctrl
